// File: ppc_port_power.sv
// ppc_port_power.sv: per-port power control and over-current sensing
//
// Summary of operation
// - each downstream port has a primary shared power-control and sense pin, plus a second such pin used when split.
// - power off drives the port pin actively low unless charging is enabled on that port.
// - pull-up stays off while the pin is driven low.
// - power on releases the driver and enables the pull-up.
// - low sensed while powered means over-current on that port.
// - sense input is filtered so short dips are not reported.
// - blown fuse low on the pin is reported the same way.
// - all ports come out of reset in non-split mode.
// - split setting is held per port and writable by software.
// - non-split port uses the primary pin for both halves.
// - split port uses a second pin for the superspeed half.
// - charging support per port, signalled through the port pin.
`timescale 1ns/10ps
`default_nettype none
module ppc_port_power
    import ppc_pkg::*;
#(
    parameter int PORTS = PPC_PORTS_DEF,
    parameter int FILT  = PPC_FILT_DEF
) (
    // clock and reset
    input  wire logic              hclk,
    input  wire logic              hresetn,
    // ahb-lite slave
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic [31:0]            hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    // primary combined pins
    input  wire logic [PORTS-1:0]  port_power_ctl_sense_i,
    output logic [PORTS-1:0]       port_power_ctl_sense_o,
    output logic [PORTS-1:0]       port_power_ctl_sense_oe,
    output logic [PORTS-1:0]       port_power_ctl_sense_pu,
    // superspeed combined pins for split ports
    input  wire logic [PORTS-1:0]  superspeed_power_ctl_sense_i,
    output logic [PORTS-1:0]       superspeed_power_ctl_sense_o,
    output logic [PORTS-1:0]       superspeed_power_ctl_sense_oe,
    output logic [PORTS-1:0]       superspeed_power_ctl_sense_pu
);
    ppc_ahb_req_t         req;
    logic [PORTS-1:0]     pwr_hs;
    logic [PORTS-1:0]     pwr_ss;
    logic [PORTS-1:0]     split;
    logic [PORTS-1:0]     charge;
    logic [PORTS-1:0]     oc_hs;
    logic [PORTS-1:0]     oc_ss;
    logic [PORTS-1:0]     fault_hs;
    logic [PORTS-1:0]     fault_ss;
    logic [PORTS-1:0]     pin_hs;
    logic [PORTS-1:0]     pin_ss;
    logic [PORTS-1:0]     ss_on;
    logic [PPC_CNT_W-1:0] hold;
    logic [31:0]          next_rdata;
    logic [31:0]          w_power;
    logic                 addr_ok;
    logic                 wr_power;
    logic                 wr_split;
    logic                 wr_charge;
    logic                 wr_ocflag;
    logic                 wr_hold;
    logic                 take;

    // superspeed fields start at bit 8, so at most 8 ports fit
    if (PORTS < 1 || PORTS > PPC_SS_LSB) begin : g_bad_ports
        $error("ppc: PORTS must be 1..8");
    end

    // address phase is taken on a selected nonseq or seq word access
    assign take = hsel && hready && htrans[1] && (hsize == 3'h2);

    // write strobes decoded from the captured address phase
    assign wr_power  = req.valid && req.write
        && req.addr == PPC_ADDR_POWER;
    assign wr_split  = req.valid && req.write
        && req.addr == PPC_ADDR_SPLIT;
    assign wr_charge = req.valid && req.write
        && req.addr == PPC_ADDR_CHARGE;
    assign wr_ocflag = req.valid && req.write
        && req.addr == PPC_ADDR_OCFLAG;
    assign wr_hold   = req.valid && req.write
        && req.addr == PPC_ADDR_HOLD;
    assign w_power   = hwdata;

    // read mux; unmapped addresses read zero with an okay response
    assign addr_ok = (haddr[11:0] == PPC_ADDR_POWER)
        || (haddr[11:0] == PPC_ADDR_SPLIT)
        || (haddr[11:0] == PPC_ADDR_CHARGE)
        || (haddr[11:0] == PPC_ADDR_OCFLAG)
        || (haddr[11:0] == PPC_ADDR_PINS)
        || (haddr[11:0] == PPC_ADDR_HOLD);
    always_comb begin
        next_rdata = PPC_RST_ZERO;
        unique case (haddr[11:0])
            PPC_ADDR_POWER: begin
                next_rdata[PORTS-1:0] = pwr_hs;
                next_rdata[PPC_SS_LSB +: PORTS] = pwr_ss;
            end
            PPC_ADDR_SPLIT:  next_rdata[PORTS-1:0] = split;
            PPC_ADDR_CHARGE: next_rdata[PORTS-1:0] = charge;
            PPC_ADDR_OCFLAG: begin
                next_rdata[PORTS-1:0] = oc_hs;
                next_rdata[PPC_SS_LSB +: PORTS] = oc_ss;
            end
            PPC_ADDR_PINS: begin
                next_rdata[PORTS-1:0] = port_power_ctl_sense_i;
                next_rdata[PPC_SS_LSB +: PORTS] =
                    superspeed_power_ctl_sense_i;
            end
            PPC_ADDR_HOLD:   next_rdata[PPC_CNT_W-1:0] = hold;
            default:         next_rdata = PPC_RST_ZERO;
        endcase
        if (!addr_ok) next_rdata = PPC_RST_ZERO;
    end

    // zero-wait slave: read data registered at the address edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req       <= '0;
            hrdata    <= PPC_RST_ZERO;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            req.valid <= take;
            req.write <= hwrite;
            req.addr  <= haddr[11:0];
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (take && !hwrite) hrdata <= next_rdata;
        end
    end

    // software-owned control; split clears to non-split on reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwr_hs <= '0;
            pwr_ss <= '0;
            split  <= '0;
            charge <= '0;
            hold   <= PPC_RST_HOLD;
        end else begin
            if (wr_power) begin
                pwr_hs <= w_power[PORTS-1:0];
                pwr_ss <= w_power[PPC_SS_LSB +: PORTS];
            end
            if (wr_split) split <= hwdata[PORTS-1:0];
            if (wr_charge) charge <= hwdata[PORTS-1:0];
            if (wr_hold) hold <= hwdata[PPC_CNT_W-1:0];
        end
    end

    // sticky faults: write one to clear, a new fault wins the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            oc_hs <= '0;
            oc_ss <= '0;
        end else begin
            oc_hs <= (oc_hs & ~({PORTS{wr_ocflag}} & hwdata[PORTS-1:0]))
                | fault_hs;
            oc_ss <= (oc_ss
                & ~({PORTS{wr_ocflag}} & hwdata[PPC_SS_LSB +: PORTS]))
                | fault_ss;
        end
    end

    // charging ports advertise the high-current supply by keeping
    // their pin released even with power off; non-split ports follow
    // the primary power bit on both halves
    assign pin_hs = pwr_hs | charge;
    assign ss_on  = split & (pwr_ss | charge);

    // one pin pair per port
    genvar g;
    generate
        for (g = 0; g < PORTS; g++) begin : g_port
            ppc_pin_drv_t drv_hs;
            ppc_pin_drv_t drv_ss;
            // the primary pin serves both halves unless split
            ppc_pin_drv u_drv_hs (
                .hclk     (hclk),
                .hresetn  (hresetn),
                .power_on (pin_hs[g]),
                .drv      (drv_hs)
            );
            // unsplit ports leave the second pin driven low, unused
            ppc_pin_drv u_drv_ss (
                .hclk     (hclk),
                .hresetn  (hresetn),
                .power_on (ss_on[g]),
                .drv      (drv_ss)
            );
            assign port_power_ctl_sense_o[g]        = drv_hs.o;
            assign port_power_ctl_sense_oe[g]       = drv_hs.oe;
            assign port_power_ctl_sense_pu[g]       = drv_hs.pu;
            assign superspeed_power_ctl_sense_o[g]  = drv_ss.o;
            assign superspeed_power_ctl_sense_oe[g] = drv_ss.oe;
            assign superspeed_power_ctl_sense_pu[g] = drv_ss.pu;
            // sense only while the pin is released; the external
            // switch or fuse pulls low against the pull-up alone
            ppc_oc_filter #(.FILT(FILT)) u_oc_hs (
                .hclk     (hclk),
                .hresetn  (hresetn),
                .enable   (drv_hs.pu),
                .sense_in (port_power_ctl_sense_i[g]),
                .hold     (hold),
                .fault    (fault_hs[g])
            );
            ppc_oc_filter #(.FILT(FILT)) u_oc_ss (
                .hclk     (hclk),
                .hresetn  (hresetn),
                .enable   (drv_ss.pu),
                .sense_in (superspeed_power_ctl_sense_i[g]),
                .hold     (hold),
                .fault    (fault_ss[g])
            );
        end
    endgenerate
endmodule
`default_nettype wire

// File: ppc_pkg.sv
// ppc_pkg.sv: constants, register map and types for port power control
package ppc_pkg;
    // geometry defaults
    localparam int PPC_PORTS_DEF      = 5;
    localparam int PPC_FILT_DEF       = 3;
    // timing: debounce figure in ns and its cycle count at 10 MHz
    localparam int PPC_CLK_NS         = 100;
    localparam int PPC_OC_HOLD_NS     = 1000;
    localparam int PPC_OC_HOLD_CYC    =
        (PPC_OC_HOLD_NS + PPC_CLK_NS - 1) / PPC_CLK_NS;
    localparam int PPC_CNT_W          = 16;
    // register byte addresses
    localparam logic [11:0] PPC_ADDR_POWER  = 12'h000;
    localparam logic [11:0] PPC_ADDR_SPLIT  = 12'h004;
    localparam logic [11:0] PPC_ADDR_CHARGE = 12'h008;
    localparam logic [11:0] PPC_ADDR_OCFLAG = 12'h00c;
    localparam logic [11:0] PPC_ADDR_PINS   = 12'h010;
    localparam logic [11:0] PPC_ADDR_HOLD   = 12'h014;
    // field positions inside the power register
    localparam int PPC_SS_LSB         = 8;
    // reset values
    localparam logic [31:0] PPC_RST_ZERO  = 32'h0000_0000;
    localparam logic [PPC_CNT_W-1:0] PPC_RST_HOLD =
        PPC_CNT_W'(PPC_OC_HOLD_CYC);
    // ahb codes
    localparam logic [1:0] PPC_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] PPC_HTRANS_SEQ    = 2'h3;
    // one combined pin as three signals
    typedef struct packed {
        logic o;
        logic oe;
        logic pu;
    } ppc_pin_drv_t;
    // captured ahb address phase
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [11:0] addr;
    } ppc_ahb_req_t;
endpackage

// File: ppc_oc_filter.sv
// ppc_oc_filter.sv: sense filter and persistence counter for one pin
`timescale 1ns/10ps
`default_nettype none
module ppc_oc_filter
    import ppc_pkg::*;
#(
    parameter int FILT = PPC_FILT_DEF
) (
    // clock and reset
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    // sense
    input  wire logic                 enable,
    input  wire logic                 sense_in,
    input  wire logic [PPC_CNT_W-1:0] hold,
    // result
    output logic                      fault
);
    logic [FILT-1:0]      shift;
    logic [PPC_CNT_W-1:0] count;
    logic                 filt_low;
    logic                 next_fault;

    // a one-sample chain cannot tell a dip from a fault
    if (FILT < 2) begin : g_bad_filt
        $error("ppc_oc_filter: FILT must be at least 2");
    end

    // majority-free filter: low only when every sample agrees
    assign filt_low   = ~|shift;
    assign next_fault = enable && filt_low && (count >= hold);

    // the sample chain clears while power is off, so a stale low
    // captured during the forced drive never leaks into a fault
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shift <= '1;
            count <= '0;
            fault <= 1'b0;
        end else begin
            shift <= enable ? {shift[FILT-2:0], sense_in} : '1;
            if (enable && filt_low && count != '1) begin
                count <= count + 1'b1;
            end else if (!(enable && filt_low)) begin
                count <= '0;
            end
            fault <= next_fault;
        end
    end
endmodule
`default_nettype wire

// File: ppc_pin_drv.sv
// ppc_pin_drv.sv: drive and pull-up control of one combined pin
`timescale 1ns/10ps
`default_nettype none
module ppc_pin_drv
    import ppc_pkg::*;
(
    // clock and reset
    input  wire logic   hclk,
    input  wire logic   hresetn,
    // control
    input  wire logic   power_on,
    // pin
    output var ppc_pin_drv_t drv
);
    ppc_pin_drv_t next_drv;

    // off: drive 0, pull-up off; on: release driver, pull-up on
    assign next_drv.o  = 1'b0;
    assign next_drv.oe = ~power_on;
    assign next_drv.pu = power_on;

    // registered so the pin never glitches between driver and pull-up
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            drv <= '{o: 1'b0, oe: 1'b1, pu: 1'b0};
        end else begin
            drv <= next_drv;
        end
    end
endmodule
`default_nettype wire

// File: ppc_port_power_assertions.sv
// ppc_port_power_assertions.sv: pin and bus checks on port power control
`timescale 1ns/10ps
`default_nettype none
module ppc_port_power_checker
    import ppc_pkg::*;
#(
    parameter int PORTS = PPC_PORTS_DEF
) (
    // clock and reset
    input wire logic             hclk,
    input wire logic             hresetn,
    // bus
    input wire logic             hsel,
    input wire logic [31:0]      haddr,
    input wire logic [1:0]       htrans,
    input wire logic             hwrite,
    input wire logic [2:0]       hsize,
    input wire logic [31:0]      hwdata,
    input wire logic             hready,
    input wire logic [31:0]      hrdata,
    input wire logic             hreadyout,
    input wire logic             hresp,
    // pins
    input wire logic [PORTS-1:0] port_power_ctl_sense_o,
    input wire logic [PORTS-1:0] port_power_ctl_sense_oe,
    input wire logic [PORTS-1:0] port_power_ctl_sense_pu,
    input wire logic [PORTS-1:0] superspeed_power_ctl_sense_oe,
    input wire logic [PORTS-1:0] superspeed_power_ctl_sense_pu
);
    default clocking dc @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // short views of the pins and of a taken word access
    wire [PORTS-1:0] p_oe = port_power_ctl_sense_oe;
    wire [PORTS-1:0] p_pu = port_power_ctl_sense_pu;
    wire [PORTS-1:0] s_oe = superspeed_power_ctl_sense_oe;
    wire [PORTS-1:0] s_pu = superspeed_power_ctl_sense_pu;
    wire             take = hsel && hready && htrans[1] && hsize == 3'h2;
    // four edges with no write: a write moves the pins three edges on
    sequence s_quiet;
        !(take && hwrite) [*4];
    endsequence
    sequence s_power_on;
        take && hwrite && haddr[11:0] == PPC_ADDR_POWER ##1 hwdata[0];
    endsequence
    AST_DRIVE_LOW: assert property (
        (p_oe & port_power_ctl_sense_o) == '0)
        else $error("primary pin driven high");
    AST_PU_OFF: assert property ((p_oe & p_pu) == '0)
        else $error("pull-up on under drive");
    AST_RELEASE: assert property ((p_oe | p_pu) == '1)
        else $error("primary pin left floating");
    AST_SS_PU_OFF: assert property ((s_oe & s_pu) == '0)
        else $error("second pull-up on under drive");
    AST_SS_RELEASE: assert property ((s_oe | s_pu) == '1)
        else $error("second pin left floating");
    AST_PIN_QUIET: assert property (
        s_quiet |-> $stable(p_pu) && $stable(s_pu))
        else $error("pin moved with no write");
    AST_POWER_ON: assert property (s_power_on |-> ##[1:2] p_pu[0])
        else $error("port 0 not released");
    AST_RDATA_HOLD: assert property (!(take && !hwrite) |=> $stable(hrdata))
        else $error("read data moved");
    AST_OKAY: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
endmodule
bind ppc_port_power ppc_port_power_checker #(.PORTS(PORTS)) u_chk (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .port_power_ctl_sense_o,
    .port_power_ctl_sense_oe, .port_power_ctl_sense_pu,
    .superspeed_power_ctl_sense_oe, .superspeed_power_ctl_sense_pu);
`default_nettype wire

// File: ppc_switch_model.sv
// ppc_switch_model.sv: external power switch on a set of combined pins
`timescale 1ns/10ps
`default_nettype none
module ppc_switch_model #(
    parameter int N = 5
) (
    // clock
    input  wire logic         hclk,
    // hub drive
    input  wire logic [N-1:0] o,
    input  wire logic [N-1:0] oe,
    input  wire logic [N-1:0] pu,
    // fault request
    input  wire logic [N-1:0] fault,
    // resolved level
    output logic [N-1:0]      level
);
    logic [N-1:0] last;
    // hub drive wins, then a fault; an unfaulted pin with no pull shows the inverse of its past
    always_comb begin
        for (int i = 0; i < N; i++) begin
            if (oe[i]) level[i] = o[i];
            else if (fault[i]) level[i] = 1'b0;
            else if (pu[i]) level[i] = 1'b1;
            else level[i] = ~last[i];
        end
    end
    always_ff @(posedge hclk) last <= level;
endmodule
`default_nettype wire

// File: tb.sv
// tb.sv: self-checking bench for port power control
`timescale 1ns/10ps
`default_nettype none
module tb;
    import ppc_pkg::*;
    localparam int P = 5;
    logic         hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, rd_ph = 1'b0;
    logic [31:0]  haddr = '0, hwdata = '0, hrdata, exp_q[$];
    logic [1:0]   htrans = 2'h0;
    logic         hreadyout;
    logic [P-1:0] p_i, p_o, p_oe, p_pu, s_i, s_o, s_oe, s_pu;
    logic [P-1:0] f_p = '0, f_s = '0;
    logic [7:0]   lfsr = 8'h1c;
    int           errors = 0, compares = 0;
    always #50 hclk = ~hclk;
    // design and two switch models, one per pin set
    ppc_port_power #(.PORTS(P), .FILT(3)) uut (.hclk(hclk),
        .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
        .port_power_ctl_sense_i(p_i), .port_power_ctl_sense_o(p_o),
        .port_power_ctl_sense_oe(p_oe), .port_power_ctl_sense_pu(p_pu),
        .superspeed_power_ctl_sense_i(s_i), .superspeed_power_ctl_sense_o(s_o),
        .superspeed_power_ctl_sense_oe(s_oe),
        .superspeed_power_ctl_sense_pu(s_pu));
    ppc_switch_model #(.N(P)) u_sw_p (.hclk(hclk), .o(p_o), .oe(p_oe),
        .pu(p_pu), .fault(f_p), .level(p_i));
    ppc_switch_model #(.N(P)) u_sw_s (.hclk(hclk), .o(s_o), .oe(s_oe),
        .pu(s_pu), .fault(f_s), .level(s_i));
    function automatic logic [7:0] lfsr_next(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    // one single transfer; both phases wait for hready
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        @(posedge hclk);
        htrans <= PPC_HTRANS_NONSEQ;
        haddr <= {20'h0, a};
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        xfer(1'b0, a, 32'h0);
    endtask
    task automatic settle;
        repeat (8) @(posedge hclk);
    endtask
    task automatic close_out;
        if (errors == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // read data phase ends: compare with the oldest note
    always @(posedge hclk) begin
        if (rd_ph && hreadyout === 1'b1 && exp_q.size() != 0)
            chk(exp_q.pop_front(), hrdata);
        rd_ph <= htrans[1] && !hwrite && hreadyout === 1'b1;
    end
    // hang guard, far past the roughly 230 cycles needed
    initial begin
        #1_000_000;
        errors++;
        close_out();
    end
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        rd(PPC_ADDR_SPLIT, 32'h0);
        rd(PPC_ADDR_HOLD, 32'(PPC_RST_HOLD));
        rd(PPC_ADDR_PINS, 32'h0);
        xfer(1'b1, 12'h018, 32'hffff_ffff);
        rd(12'h018, 32'h0);
        xfer(1'b1, PPC_ADDR_HOLD, 32'h1);
        // random power patterns: powered pins pulled high, others low
        for (int k = 0; k < 4; k++) begin
            lfsr = lfsr_next(lfsr);
            xfer(1'b1, PPC_ADDR_POWER, {27'h0, lfsr[4:0]});
            settle();
            rd(PPC_ADDR_PINS, {27'h0, lfsr[4:0]});
        end
        rd(PPC_ADDR_OCFLAG, 32'h0);
        xfer(1'b1, PPC_ADDR_POWER, 32'h3);
        // one-cycle dip on port 1 must be filtered away
        @(posedge hclk) f_p <= 5'h2;
        @(posedge hclk) f_p <= 5'h0;
        settle();
        rd(PPC_ADDR_OCFLAG, 32'h0);
        // lasting low on powered port 0 and on unpowered port 2
        @(posedge hclk) f_p <= 5'h5;
        repeat (20) @(posedge hclk);
        rd(PPC_ADDR_PINS, 32'h2);
        rd(PPC_ADDR_OCFLAG, 32'h1);
        @(posedge hclk) f_p <= 5'h0;
        settle();
        rd(PPC_ADDR_OCFLAG, 32'h1);
        xfer(1'b1, PPC_ADDR_OCFLAG, 32'h1);
        rd(PPC_ADDR_OCFLAG, 32'h0);
        // split port 0: second pin carries the superspeed half
        xfer(1'b1, PPC_ADDR_SPLIT, 32'h1);
        rd(PPC_ADDR_SPLIT, 32'h1);
        xfer(1'b1, PPC_ADDR_POWER, 32'h100);
        settle();
        rd(PPC_ADDR_PINS, 32'h100);
        @(posedge hclk) f_s <= 5'h1;
        repeat (20) @(posedge hclk);
        rd(PPC_ADDR_OCFLAG, 32'h100);
        @(posedge hclk) f_s <= 5'h0;
        settle();
        xfer(1'b1, PPC_ADDR_OCFLAG, 32'h100);
        // back to non-split: second pin driven low again
        xfer(1'b1, PPC_ADDR_SPLIT, 32'h0);
        settle();
        rd(PPC_ADDR_PINS, 32'h0);
        // charge bit alone releases the pin of port 3
        xfer(1'b1, PPC_ADDR_CHARGE, 32'h8);
        settle();
        rd(PPC_ADDR_PINS, 32'h8);
        close_out();
    end
endmodule
`default_nettype wire
